//--- logic/mcu_exec_regs.svh
// Named constants for the subtract, special page and sleep execution logic.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MCU_EXEC_REGS_SVH
`define MCU_EXEC_REGS_SVH

`define DATA_W          8
`define SEL_W           4
`define PAGE_DEPTH      16
`define PAGE_RST        8'h00
`define WORK_RST        8'h00
`define ZERO_BYTE       8'h00
`define NIB_LSB_W       4
`define SUM_CARRY_BIT   8
`define NIB_CARRY_BIT   4
`define CARRY_RST       1'b0
`define ZERO_RST        1'b0
`define HALF_CARRY_RST  1'b0
`define EXPIRY_N_RST    1'b1
`define HALT_N_RST      1'b1
`define EXPIRY_N_SLEEP  1'b1
`define HALT_N_SLEEP    1'b0

`endif

//--- logic/mcu_exec_pkg.sv
// Types shared by the execution logic and its special page file.
// Assumes the constant header is on the include path.
`include "mcu_exec_regs.svh"

package mcu_exec_pkg;

  typedef enum logic [2:0]
  {
    OP_NOP   = 3'h0,
    OP_SBC   = 3'h1,
    OP_SPR   = 3'h2,
    OP_SPW   = 3'h3,
    OP_SLEEP = 3'h4,
    OP_LDW   = 3'h5,
    OP_LDC   = 3'h6
  } op_t;

  typedef enum logic [0:0]
  {
    ST_RUN  = 1'h0,
    ST_HALT = 1'h1
  } state_t;

  typedef logic [`DATA_W-1:0] byte_t;
  typedef logic [`SEL_W-1:0]  sel_t;

endpackage : mcu_exec_pkg

//--- logic/page_bus_if.sv
// Carrier between the execution core and its special page file.
// Assumes both ends run on the same single clock.
`timescale 1ns/100ps
`default_nettype none

interface page_bus_if;
  logic                 wr_en;
  mcu_exec_pkg::sel_t   wr_sel;
  mcu_exec_pkg::byte_t  wr_data;
  mcu_exec_pkg::sel_t   rd_sel;
  mcu_exec_pkg::byte_t  rd_data;

  modport core (output wr_en, output wr_sel, output wr_data, output rd_sel, input rd_data);
  modport page (input wr_en, input wr_sel, input wr_data, input rd_sel, output rd_data);
endinterface : page_bus_if

`default_nettype wire

//--- logic/special_page_file.sv
// Sixteen byte special page register file with one write and one read port.
// Assumes the core drives the write strobe for one cycle per store.
`timescale 1ns/100ps
`default_nettype none
`include "mcu_exec_regs.svh"

module special_page_file
(
  // Clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  // Core side
  page_bus_if.page   bus
);

  mcu_exec_pkg::byte_t special_page_register [`PAGE_DEPTH];

  genvar g;
  generate
    for (g = 0; g < `PAGE_DEPTH; g++)
    begin : g_entry
      wire logic hit;
      assign hit = bus.wr_en && (bus.wr_sel == mcu_exec_pkg::sel_t'(g));
      always_ff @(posedge i_clk or posedge i_rst)
      begin
        if (i_rst)
          special_page_register[g] <= `PAGE_RST;
        else if (hit)
          special_page_register[g] <= bus.wr_data;
      end
    end
  endgenerate

  // Read is combinational so a load completes in the cycle it is issued.
  assign bus.rd_data = special_page_register[bus.rd_sel];

endmodule : special_page_file

`default_nettype wire

//--- logic/mcu_exec.sv
// Execution logic for subtract with borrow from immediate, special page
// moves and the sleep instruction of an 8-bit core.
// Assumes one instruction is presented per cycle with i_valid, synchronous
// to i_clk; the watchdog itself lives outside and obeys o_watchdog_clear.
`timescale 1ns/100ps
`default_nettype none
`include "mcu_exec_regs.svh"

module mcu_exec
(
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // Instruction stream
  input  wire logic                 i_valid,
  input  wire mcu_exec_pkg::op_t    i_op,
  input  wire mcu_exec_pkg::byte_t  i_imm,
  input  wire mcu_exec_pkg::sel_t   i_sel,
  // Wake request from outside the block
  input  wire logic                 i_wake,
  // Core state
  output var  mcu_exec_pkg::byte_t  o_working_register,
  output var  logic                 o_carry_flag,
  output var  logic                 o_zero_flag,
  output var  logic                 o_half_carry_flag,
  output var  logic                 o_watchdog_expiry_flag_n,
  output var  logic                 o_halt_entry_flag_n,
  output var  logic                 o_halted,
  // Events
  output var  logic                 o_done,
  output var  logic                 o_watchdog_clear
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  mcu_exec_pkg::state_t state;
  mcu_exec_pkg::state_t next_state;

  wire logic accept;
  wire logic is_sbc;
  wire logic is_spr;
  wire logic is_spw;
  wire logic is_sleep;
  wire logic is_ldw;
  wire logic is_ldc;

  // Instructions arriving while halted are dropped, not queued.
  assign accept   = i_valid && (state == mcu_exec_pkg::ST_RUN);
  assign is_sbc   = accept && (i_op == mcu_exec_pkg::OP_SBC);
  assign is_spr   = accept && (i_op == mcu_exec_pkg::OP_SPR);
  assign is_spw   = accept && (i_op == mcu_exec_pkg::OP_SPW);
  assign is_sleep = accept && (i_op == mcu_exec_pkg::OP_SLEEP);
  assign is_ldw   = accept && (i_op == mcu_exec_pkg::OP_LDW);
  assign is_ldc   = accept && (i_op == mcu_exec_pkg::OP_LDC);

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic

  wire logic [`DATA_W:0]    sbc_sum;
  wire logic [`NIB_LSB_W:0] sbc_nib;
  wire mcu_exec_pkg::byte_t inv_work;

  assign inv_work = ~o_working_register;
  assign sbc_sum  = {1'b0, i_imm} + {1'b0, inv_work}
                  + {{`DATA_W{1'b0}}, o_carry_flag};
  assign sbc_nib  = {1'b0, i_imm[`NIB_LSB_W-1:0]}
                  + {1'b0, inv_work[`NIB_LSB_W-1:0]}
                  + {{`NIB_LSB_W{1'b0}}, o_carry_flag};

  ////////////////////////////////////////////////////////////////////////////
  // Special page file

  page_bus_if page_bus ();

  assign page_bus.wr_en   = is_spw;
  assign page_bus.wr_sel  = i_sel;
  assign page_bus.wr_data = o_working_register;
  assign page_bus.rd_sel  = i_sel;

  special_page_file u_page
  (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .bus   (page_bus.page)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next values

  mcu_exec_pkg::byte_t next_work;
  logic                next_carry;
  logic                next_zero;
  logic                next_half_carry;

  // Only the subtract writes the carry, zero and half carry flags besides the test load of carry.
  assign next_work       = is_sbc ? sbc_sum[`DATA_W-1:0] :
                           is_spr ? page_bus.rd_data :
                           is_ldw ? i_imm : o_working_register;
  assign next_carry      = is_sbc ? sbc_sum[`SUM_CARRY_BIT] :
                           is_ldc ? i_imm[0] : o_carry_flag;
  assign next_zero       = is_sbc ? (sbc_sum[`DATA_W-1:0] == `ZERO_BYTE)
                                  : o_zero_flag;
  assign next_half_carry = is_sbc ? sbc_nib[`NIB_CARRY_BIT]
                                  : o_half_carry_flag;
  assign next_state      = is_sleep ? mcu_exec_pkg::ST_HALT :
                           (state == mcu_exec_pkg::ST_HALT && i_wake)
                             ? mcu_exec_pkg::ST_RUN : state;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_working_register <= `WORK_RST;
      o_carry_flag       <= `CARRY_RST;
      o_zero_flag        <= `ZERO_RST;
      o_half_carry_flag  <= `HALF_CARRY_RST;
    end
    else
    begin
      o_working_register <= next_work;
      o_carry_flag       <= next_carry;
      o_zero_flag        <= next_zero;
      o_half_carry_flag  <= next_half_carry;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state            <= mcu_exec_pkg::ST_RUN;
      o_halted         <= 1'b0;
      o_done           <= 1'b0;
      o_watchdog_clear <= 1'b0;
    end
    else
    begin
      state            <= next_state;
      o_halted         <= (next_state == mcu_exec_pkg::ST_HALT);
      o_done           <= accept;
      o_watchdog_clear <= is_sleep;
    end
  end

  // Both status flags keep their sleep values across wake; only reset
  // restores them, since no other input of this block writes them.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_watchdog_expiry_flag_n <= `EXPIRY_N_RST;
      o_halt_entry_flag_n      <= `HALT_N_RST;
    end
    else if (is_sleep)
    begin
      o_watchdog_expiry_flag_n <= `EXPIRY_N_SLEEP;
      o_halt_entry_flag_n      <= `HALT_N_SLEEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sbc_result_a: assert property (is_sbc |=> o_working_register == $past(next_work)
                                 && o_working_register == $past(i_imm) + $past(inv_work)
                                    + {{(`DATA_W-1){1'b0}}, $past(o_carry_flag)})
    else $error("Subtract result not placed in working register.");

  sbc_carry_a: assert property (is_sbc |=> o_carry_flag
                                == $past(sbc_sum[`SUM_CARRY_BIT]))
    else $error("Subtract carry wrong.");

  sbc_zero_a: assert property (is_sbc |=> o_zero_flag
                               == (o_working_register == `ZERO_BYTE))
    else $error("Zero flag disagrees with subtract result.");

  sbc_half_carry_a: assert property (is_sbc |=> o_half_carry_flag
                                     == $past(sbc_nib[`NIB_CARRY_BIT]))
    else $error("Half carry wrong after subtract.");

  page_read_a: assert property (is_spr |=> o_working_register == $past(page_bus.rd_data)
                                && $stable(o_carry_flag) && $stable(o_zero_flag)
                                && $stable(o_half_carry_flag))
    else $error("Special page read wrong or flags disturbed.");

  page_write_a: assert property (is_spw ##1 (i_valid && i_op == mcu_exec_pkg::OP_SPR
                                 && i_sel == $past(i_sel) && !o_halted)
                                 |=> o_working_register == $past(o_working_register, 2))
    else $error("Special page write not read back.");

  page_write_flags_a: assert property (is_spw |=> $stable(o_carry_flag)
                                       && $stable(o_zero_flag)
                                       && $stable(o_working_register))
    else $error("Special page write disturbed core state.");

  sleep_halt_a: assert property (is_sleep |=> o_watchdog_clear && o_halted
                                 ##1 !o_watchdog_clear)
    else $error("Sleep did not clear watchdog once and halt.");

  sleep_flags_a: assert property (is_sleep |=> o_watchdog_expiry_flag_n
                                  && !o_halt_entry_flag_n)
    else $error("Sleep status flags wrong.");

  one_cycle_a: assert property (accept |=> o_done ##0 !$past(o_halted))
    else $error("Instruction did not complete in one cycle.");

  halt_hold_a: assert property (o_halted && !i_wake |=> $stable(o_working_register)
                                && !o_done)
    else $error("Instruction executed while halted.");

  sbc_cov_c:   cover property (is_sbc ##1 o_zero_flag);
  page_cov_c:  cover property (is_spw ##1 is_spr);
  sleep_cov_c: cover property (is_sleep ##[1:4] (o_halted && i_wake) ##1 !o_halted);

endmodule : mcu_exec

`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the subtract, special page and sleep logic.
// Assumes the design files under logic/ are compiled before this file.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic                i_clk   = 1'b0;
  logic                i_rst   = 1'b1;
  logic                i_valid = 1'b0;
  mcu_exec_pkg::op_t   i_op    = mcu_exec_pkg::OP_NOP;
  mcu_exec_pkg::byte_t i_imm   = 8'h00;
  mcu_exec_pkg::sel_t  i_sel   = 4'h0;
  logic                i_wake  = 1'b0;
  mcu_exec_pkg::byte_t o_w;
  logic                o_c, o_z, o_dc, o_exp_n, o_halt_n, o_halted, o_done, o_clr;
  mcu_exec_pkg::byte_t w, page [16];
  logic                c, z, dc, pend;
  logic [31:0]         rnd;
  int                  n_mismatch, n_tests, cyc;
  mcu_exec_pkg::op_t   ops [5];

  always #50 i_clk = ~i_clk;

  mcu_exec mcu_exec_i
  (
    .i_clk                    (i_clk),
    .i_rst                    (i_rst),
    .i_valid                  (i_valid),
    .i_op                     (i_op),
    .i_imm                    (i_imm),
    .i_sel                    (i_sel),
    .i_wake                   (i_wake),
    .o_working_register       (o_w),
    .o_carry_flag             (o_c),
    .o_zero_flag              (o_z),
    .o_half_carry_flag        (o_dc),
    .o_watchdog_expiry_flag_n (o_exp_n),
    .o_halt_entry_flag_n      (o_halt_n),
    .o_halted                 (o_halted),
    .o_done                   (o_done),
    .o_watchdog_clear         (o_clr)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
  endfunction : lfsr

  // Returns the expected half carry, carry and byte of imm + ~w + c.
  function automatic logic [9:0] sbc(input logic [7:0] i, input logic [7:0] a, input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, i} + {1'b0, ~a} + {8'h00, ci};
    h = {1'b0, i[3:0]} + {1'b0, ~a[3:0]} + {4'h0, ci};
    return {h[4], s};
  endfunction : sbc

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
  begin
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  end
  endtask : chk

  task automatic close_out();
  begin
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask : close_out

  // Checks the results of the instruction taken at the last edge.
  task automatic check_prev();
  begin
    chk("working", w, o_w);
    chk("flags", {5'h00, dc, z, c}, {5'h00, o_dc, o_z, o_c});
    chk("done", {7'h00, pend}, {7'h00, o_done});
  end
  endtask : check_prev

  // Called at a rising edge; valid stays high so calls issue back to back.
  // The previous instruction is checked at the falling edge in between.
  task automatic run(input mcu_exec_pkg::op_t op, input logic [7:0] imm, input logic [3:0] sel);
    logic [9:0] r;
  begin
    i_valid <= 1'b1;
    i_op    <= op;
    i_imm   <= imm;
    i_sel   <= sel;
    @(negedge i_clk);
    check_prev();
    r = sbc(imm, w, c);
    if (op == mcu_exec_pkg::OP_SBC)
      {dc, c, w} = r;
    if (op == mcu_exec_pkg::OP_SBC)
      z = (r[7:0] == 8'h00);
    if (op == mcu_exec_pkg::OP_LDW)
      w = imm;
    if (op == mcu_exec_pkg::OP_LDC)
      c = imm[0];
    if (op == mcu_exec_pkg::OP_SPW)
      page[sel] = w;
    if (op == mcu_exec_pkg::OP_SPR)
      w = page[sel];
    pend = 1'b1;
    @(posedge i_clk);
  end
  endtask : run

  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ops = '{mcu_exec_pkg::OP_SBC, mcu_exec_pkg::OP_SPR, mcu_exec_pkg::OP_SPW,
            mcu_exec_pkg::OP_LDW, mcu_exec_pkg::OP_LDC};
    {w, c, z, dc, pend} = '0;
    foreach (page[k]) page[k] = 8'h00;
    rnd = 32'he951;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    chk("reset", 8'h0c, {o_w[3:0], o_exp_n, o_halt_n, o_halted, o_clr});
    chk("reset flags", 8'h00, {o_w[7:4], o_c, o_z, o_dc, o_done});
    @(posedge i_clk);
    run(mcu_exec_pkg::OP_SPR, 8'h00, 4'hf);
    // The four worked subtract examples, then a walk over every page index.
    for (int k = 0; k < 4; k++)
    begin
      run(mcu_exec_pkg::OP_LDW, (k < 2) ? 8'h06 : 8'h05, 4'h0);
      run(mcu_exec_pkg::OP_LDC, {7'h00, k[0]}, 4'h0);
      run(mcu_exec_pkg::OP_SBC, (k < 2) ? 8'h05 : 8'h06, 4'h0);
    end
    for (int k = 0; k < 16; k++)
    begin
      run(mcu_exec_pkg::OP_LDW, 8'h11 * k[7:0] + 8'h3c, 4'h0);
      run(mcu_exec_pkg::OP_SPW, 8'h00, k[3:0]);
      run(mcu_exec_pkg::OP_SPR, 8'h00, k[3:0]);
    end
    for (int k = 0; k < 16; k++)
      run(mcu_exec_pkg::OP_SPR, 8'h00, k[3:0]);
    repeat (60)
    begin
      rnd = lfsr(rnd);
      run(ops[rnd[2:0] % 5], rnd[15:8], rnd[19:16]);
    end
    run(mcu_exec_pkg::OP_SLEEP, 8'h00, 4'h0);
    @(negedge i_clk);
    check_prev();
    chk("sleep", 8'h0e, {4'h0, o_clr, o_halted, o_exp_n, o_halt_n});
    pend = 1'b0;
    @(posedge i_clk);
    // Instructions offered while halted must be ignored.
    i_op  <= mcu_exec_pkg::OP_SBC;
    i_imm <= 8'h5a;
    repeat (3)
    begin
      @(negedge i_clk);
      chk("halted", 8'h06, {o_done, o_clr, o_halted, o_exp_n, o_halt_n});
      chk("halt hold", w, o_w);
      @(posedge i_clk);
    end
    i_wake <= 1'b1;
    @(posedge i_clk);
    i_wake  <= 1'b0;
    i_valid <= 1'b0;
    @(negedge i_clk);
    chk("wake", 8'h02, {o_done, o_halted, o_exp_n, o_halt_n});
    chk("wake hold", w, o_w);
    @(posedge i_clk);
    run(mcu_exec_pkg::OP_SBC, 8'h00, 4'h0);
    @(negedge i_clk);
    check_prev();
    close_out();
  end
endmodule : testbench

`default_nettype wire
